// file: hdl/dpbrw_host.sv
/*
 dpbrw_host: requester that builds data port messages (block read,
 block write, streamed vertex write) from apb registers and streams
 them dword by dword; block reads collect 32 writeback dwords.
 assumes: device accepts a dword on msg_valid and msg_ready high,
 writeback dwords arrive in order on wb_valid while wb_ready is high.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// - dispatch id sent in header dword 5
// - y offset signed, four row aligned
// - x offset signed, eight pixel aligned
// - first register: channels 1/0, pixels 0-15
// - second register: channels 1/0, pixels 16-31
// - channels 3/2 follow in two more
// - element index below two to 27
// - streamed write never ends the thread
// - streamed write never uses index 255
// - target untiled, dword aligned surface
module dpbrw_host (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic [dpbrw_pkg::DPBRW_ADDR_W-1:0] paddr,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   output logic                                  msg_valid,
   input  wire logic                             msg_ready,
   output logic      [31:0]                      msg_data,
   output logic                                  msg_last,
   output logic      [1:0]                       msg_kind,
   output logic      [dpbrw_pkg::DPBRW_DESC_W-1:0] msg_desc,
   output logic                                  msg_eot,
   output logic      [3:0]                       msg_exec,
   input  wire logic                             wb_valid,
   input  wire logic [31:0]                      wb_data,
   output logic                                  wb_ready
);
   import dpbrw_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WB} dpbrw_st_type;

   dpbrw_st_type   st_q, st_d;
   logic [31:0]    pix_q [32];
   logic [31:0]    pix_d [32];
   logic [31:0]    xoff_q, xoff_d, yoff_q, yoff_d, mask_q, mask_d;
   logic [31:0]    didx_q, didx_d;
   logic [7:0]     disp_q, disp_d, bti_q, bti_d;
   logic [3:0]     exec_q, exec_d;
   dpbrw_kind_type kind_q, kind_d;
   logic           eot_q, eot_d, done_q, done_d, err_q, err_d;
   logic [2:0]     flags_q, flags_d;
   logic [5:0]     beat_q, beat_d;
   logic [4:0]     wbc_q, wbc_d;
   logic [31:0]    mdata_q, mdata_d, prdata_q, prdata_d;
   logic           mvalid_q, mvalid_d, mlast_q, mlast_d, wbr_q, wbr_d;
   logic           pready_q, pready_d, pslverr_q, pslverr_d;
   logic [1:0]     mkind_q, mkind_d;
   logic [DPBRW_DESC_W-1:0] mdesc_q, mdesc_d;
   logic           meot_q, meot_d;
   logic [3:0]     mexec_q, mexec_d;
   logic [5:0]     nbeat;
   logic [5:0]     pay_beat;
   logic [4:0]     pk_num, pk_lo, pk_hi;
   logic           pk_chan;
   logic           mapped;
   logic           wr_take;

   //////////////////////////////////////////////////////////////////////
   // apb answer: one wait state, so the read mux is registered

   always_comb begin
      mapped = (paddr[1:0] == 2'h0) &&
               (paddr[DPBRW_PIX_SEL_BIT] ||
                (paddr <= DPBRW_EXEC_OFS));
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0;
      if (psel && penable && !pready_q) begin
         pready_d  = 1'b1;
         pslverr_d = !mapped;
         if (paddr[DPBRW_PIX_SEL_BIT]) begin
            prdata_d = pix_q[paddr[6:2]];
         end else begin
            unique case (paddr)
               DPBRW_CTRL_OFS:   prdata_d = {25'h0, flags_q, eot_q,
                                             kind_q, 1'b0};
               DPBRW_STATUS_OFS: prdata_d = {29'h0, err_q, done_q,
                                             st_q != ST_IDLE};
               DPBRW_XOFF_OFS:   prdata_d = xoff_q;
               DPBRW_YOFF_OFS:   prdata_d = yoff_q;
               DPBRW_MASK_OFS:   prdata_d = mask_q;
               DPBRW_DISP_OFS:   prdata_d = {24'h0, disp_q};
               DPBRW_BTI_OFS:    prdata_d = {24'h0, bti_q};
               DPBRW_DIDX_OFS:   prdata_d = didx_q;
               DPBRW_EXEC_OFS:   prdata_d = {28'h0, exec_q};
               default:          prdata_d = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // dword mapping for payload and writeback

   assign nbeat    = (st_q == ST_IDLE) ? 6'h00 : beat_q + 6'h01;
   assign pay_beat = nbeat - DPBRW_HDR_BEATS;
   assign pk_num   = (st_q == ST_WB) ? wbc_q : pay_beat[4:0];

   dpbrw_pack u_pack (
      .dword_num (pk_num),
      .pix_lo    (pk_lo),
      .pix_hi    (pk_hi),
      .chan_hi   (pk_chan)
   );

   //////////////////////////////////////////////////////////////////////
   // registers, message sequencer and writeback capture

   always_comb begin
      logic           start;
      logic           bad;
      logic           done_set;
      logic           err_set;
      dpbrw_kind_type kv;
      logic [31:0]    plo, phi;
      logic [31:0]    bdata;
      start    = 1'b0;
      bad      = 1'b0;
      done_set = 1'b0;
      err_set  = 1'b0;
      plo      = pix_q[pk_lo];
      phi      = pix_q[pk_hi];
      bdata    = 32'h0;
      // a refused address must not leak into the pixel store
      wr_take  = psel && penable && pwrite && pready_q && mapped;
      st_d = st_q;   xoff_d = xoff_q; yoff_d = yoff_q; mask_d = mask_q;
      didx_d = didx_q; disp_d = disp_q; bti_d = bti_q; exec_d = exec_q;
      kind_d = kind_q; eot_d = eot_q; flags_d = flags_q;
      done_d = done_q; err_d = err_q;
      beat_d = beat_q; wbc_d = wbc_q; mdata_d = mdata_q;
      mvalid_d = mvalid_q; mlast_d = mlast_q; wbr_d = wbr_q;
      mkind_d = mkind_q; mdesc_d = mdesc_q; meot_d = meot_q;
      mexec_d = mexec_q;
      pix_d = pix_q;
      // configuration is frozen while a message is in flight
      if (wr_take && st_q == ST_IDLE) begin
         if (paddr[DPBRW_PIX_SEL_BIT]) begin
            pix_d[paddr[6:2]] = pwdata;
         end else begin
            unique case (paddr)
               DPBRW_CTRL_OFS: begin
                  start   = pwdata[DPBRW_START_BIT];
                  kind_d  = dpbrw_kind_type'(pwdata[DPBRW_KIND_LSB +: 2]);
                  eot_d   = pwdata[DPBRW_EOT_BIT];
                  flags_d = pwdata[DPBRW_FLAGS_LSB +: 3];
               end
               DPBRW_XOFF_OFS: xoff_d = pwdata;
               DPBRW_YOFF_OFS: yoff_d = pwdata;
               DPBRW_MASK_OFS: mask_d = pwdata;
               DPBRW_DISP_OFS: disp_d = pwdata[7:0];
               DPBRW_BTI_OFS:  bti_d  = pwdata[7:0];
               DPBRW_DIDX_OFS: didx_d = pwdata;
               DPBRW_EXEC_OFS: exec_d = pwdata[3:0];
               default: ;
            endcase
         end
      end
      kv = kind_d;
      // header and payload dword for beat nbeat
      if (nbeat < DPBRW_HDR_BEATS) begin
         if (kv == DPBRW_KIND_SV_WR) begin
            if (nbeat[2:0] <= DPBRW_SV_A) begin
               bdata = pix_q[nbeat[1:0]];
            end else if (nbeat[2:0] == DPBRW_SV_IDX) begin
               bdata = didx_q;
            end
         end else begin
            unique case (nbeat[2:0])
               DPBRW_HDR_X:    bdata = xoff_q;
               DPBRW_HDR_Y:    bdata = yoff_q;
               DPBRW_HDR_MASK: bdata = mask_q;
               DPBRW_HDR_DISP: bdata = {24'h0, disp_q};
               default:        bdata = 32'h0;
            endcase
         end
      end else if (pk_chan) begin
         bdata = {phi[31:24], phi[23:16], plo[31:24], plo[23:16]};
      end else begin
         bdata = {phi[15:8], phi[7:0], plo[15:8], plo[7:0]};
      end
      unique case (st_q)
         ST_IDLE: begin
            if (start) begin
               bad = (kv == DPBRW_KIND_BAD) ||
                     ((kv != DPBRW_KIND_SV_WR) &&
                      ((xoff_q[DPBRW_X_ALIGN_W-1:0] != '0) ||
                       (yoff_q[DPBRW_Y_ALIGN_W-1:0] != '0))) ||
                     ((kv == DPBRW_KIND_SV_WR) &&
                      ((didx_q[31:DPBRW_DIDX_TOP] != '0) ||
                       eot_d ||
                       (bti_q == DPBRW_BTI_STATELESS)));
               if (bad) begin
                  err_set = 1'b1;
               end else begin
                  st_d     = ST_SEND;
                  beat_d   = 6'h00;
                  mvalid_d = 1'b1;
                  mlast_d  = 1'b0;
                  mdata_d  = bdata;
                  mkind_d  = kv;
                  // surface tiling and alignment stay with software
                  mdesc_d  = {2'h0, flags_d, bti_q};
                  meot_d   = eot_d;
                  mexec_d  = exec_q;
               end
            end
         end
         ST_SEND: begin
            if (msg_ready) begin
               if (mlast_q) begin
                  mvalid_d = 1'b0;
                  mlast_d  = 1'b0;
                  if (mkind_q == DPBRW_KIND_BLK_RD) begin
                     st_d  = ST_WB;
                     wbr_d = 1'b1;
                     wbc_d = 5'h00;
                  end else begin
                     st_d     = ST_IDLE;
                     done_set = 1'b1;
                  end
               end else begin
                  beat_d  = nbeat;
                  mdata_d = bdata;
                  mlast_d = (mkind_q == DPBRW_KIND_BLK_WR) ?
                            (nbeat == DPBRW_BLK_WR_BEATS - 6'h01) :
                            (nbeat == DPBRW_HDR_BEATS - 6'h01);
               end
            end
         end
         ST_WB: begin
            if (wb_valid) begin
               // writeback uses the write payload layout
               if (pk_chan) begin
                  pix_d[pk_lo][31:16] = wb_data[15:0];
                  pix_d[pk_hi][31:16] = wb_data[31:16];
               end else begin
                  pix_d[pk_lo][15:0] = wb_data[15:0];
                  pix_d[pk_hi][15:0] = wb_data[31:16];
               end
               wbc_d = wbc_q + 5'h01;
               if (wbc_q == DPBRW_WB_LAST) begin
                  st_d     = ST_IDLE;
                  wbr_d    = 1'b0;
                  done_set = 1'b1;
               end
            end
         end
      endcase
      // write one to clear; a same-cycle set wins
      if (wr_take && paddr == DPBRW_STATUS_OFS) begin
         done_d = done_q && !pwdata[DPBRW_DONE_BIT];
         err_d  = err_q && !pwdata[DPBRW_ERR_BIT];
      end
      done_d = done_d || done_set;
      err_d  = err_d || err_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;   xoff_q <= 32'h0; yoff_q <= 32'h0;
         mask_q <= 32'h0;   didx_q <= 32'h0; disp_q <= 8'h0;
         bti_q <= 8'h0;     exec_q <= 4'h0;  kind_q <= DPBRW_KIND_BLK_RD;
         eot_q <= 1'b0;     flags_q <= 3'h0; done_q <= 1'b0;
         err_q <= 1'b0;     beat_q <= 6'h00; wbc_q <= 5'h00;
         mdata_q <= 32'h0;  mvalid_q <= 1'b0; mlast_q <= 1'b0;
         wbr_q <= 1'b0;     mkind_q <= 2'h0;  mdesc_q <= '0;
         meot_q <= 1'b0;    mexec_q <= 4'h0;
         for (int i = 0; i < 32; i++) begin
            pix_q[i] <= 32'h0;
         end
      end else begin
         st_q <= st_d;      xoff_q <= xoff_d; yoff_q <= yoff_d;
         mask_q <= mask_d;  didx_q <= didx_d; disp_q <= disp_d;
         bti_q <= bti_d;    exec_q <= exec_d; kind_q <= kind_d;
         eot_q <= eot_d;    flags_q <= flags_d; done_q <= done_d;
         err_q <= err_d;    beat_q <= beat_d; wbc_q <= wbc_d;
         mdata_q <= mdata_d; mvalid_q <= mvalid_d; mlast_q <= mlast_d;
         wbr_q <= wbr_d;    mkind_q <= mkind_d; mdesc_q <= mdesc_d;
         meot_q <= meot_d;  mexec_q <= mexec_d;
         pix_q <= pix_d;
      end
   end

   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign msg_valid = mvalid_q;
   assign msg_data  = mdata_q;
   assign msg_last  = mlast_q;
   assign msg_kind  = mkind_q;
   assign msg_desc  = mdesc_q;
   assign msg_eot   = meot_q;
   assign msg_exec  = mexec_q;
   assign wb_ready  = wbr_q;

   //////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic blk;
   assign blk = (mkind_q != DPBRW_KIND_SV_WR);

   disp_hdr_a: assert property (mvalid_q && blk && beat_q == 6'h05
      |-> mdata_q == {24'h0, disp_q})
      else $error("dispatch id not in header dword 5");
   y_align_a: assert property (mvalid_q && blk && beat_q == 6'h01
      |-> mdata_q[1:0] == 2'h0)
      else $error("y offset not four row aligned");
   x_align_a: assert property (mvalid_q && blk && beat_q == 6'h00
      |-> mdata_q[2:0] == 3'h0)
      else $error("x offset not eight pixel aligned");
   pay_first_a: assert property (mvalid_q && beat_q == 6'h09
      |-> mdata_q == {pix_q[3][15:0], pix_q[2][15:0]})
      else $error("first payload register dword 1 wrong");
   pay_second_a: assert property (mvalid_q && beat_q == 6'h10
      |-> mdata_q == {pix_q[17][15:0], pix_q[16][15:0]})
      else $error("second payload register dword 0 wrong");
   pay_alpha_a: assert property (mvalid_q && beat_q == 6'h1c
      |-> mdata_q == {pix_q[5][31:16], pix_q[4][31:16]})
      else $error("channel 3/2 payload dword 4 wrong");
   sv_index_a: assert property (mvalid_q && !blk && beat_q == 6'h05
      |-> mdata_q[31:27] == 5'h00)
      else $error("element index out of range");
   sv_eot_a: assert property (mvalid_q && !blk |-> !meot_q)
      else $error("streamed write marked end of thread");
   sv_bti_a: assert property (mvalid_q && !blk
      |-> mdesc_q[7:0] != DPBRW_BTI_STATELESS)
      else $error("streamed write uses stateless index");
   hold_beat_a: assert property (mvalid_q && !msg_ready
      |=> mvalid_q && $stable(mdata_q) && $stable(beat_q))
      else $error("message dword changed before acceptance");
   apb_wait_a: assert property (psel && penable && !pready_q
      |=> pready_q ##1 !pready_q)
      else $error("apb answer not one wait state");

   wr_done_c: cover property (mvalid_q && mlast_q && msg_ready &&
      mkind_q == DPBRW_KIND_BLK_WR);
   rd_done_c: cover property (wbr_q && wb_valid && wbc_q == DPBRW_WB_LAST);
   sv_done_c: cover property (mvalid_q && mlast_q && msg_ready && !blk);
   err_c:     cover property (!err_q ##1 err_q);

endmodule // dpbrw_host

`default_nettype wire

// file: hdl/dpbrw_pkg.sv
/*
 dpbrw_pkg: register map, field positions, message encodings and
 counts shared by the data port requester controller.
 assumes: 32-bit apb data, one aligned word per register.
*/
package dpbrw_pkg;

   localparam int          DPBRW_ADDR_W      = 8;

   // own register map
   localparam logic [7:0]  DPBRW_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  DPBRW_STATUS_OFS  = 8'h04;
   localparam logic [7:0]  DPBRW_XOFF_OFS    = 8'h08;
   localparam logic [7:0]  DPBRW_YOFF_OFS    = 8'h0c;
   localparam logic [7:0]  DPBRW_MASK_OFS    = 8'h10;
   localparam logic [7:0]  DPBRW_DISP_OFS    = 8'h14;
   localparam logic [7:0]  DPBRW_BTI_OFS     = 8'h18;
   localparam logic [7:0]  DPBRW_DIDX_OFS    = 8'h1c;
   localparam logic [7:0]  DPBRW_EXEC_OFS    = 8'h20;
   localparam int          DPBRW_PIX_SEL_BIT = 7;

   // control fields
   localparam int          DPBRW_START_BIT   = 0;
   localparam int          DPBRW_KIND_LSB    = 1;
   localparam int          DPBRW_EOT_BIT     = 3;
   localparam int          DPBRW_FLAGS_LSB   = 4;

   // status fields
   localparam int          DPBRW_BUSY_BIT    = 0;
   localparam int          DPBRW_DONE_BIT    = 1;
   localparam int          DPBRW_ERR_BIT     = 2;

   typedef enum logic [1:0] {
      DPBRW_KIND_BLK_RD = 2'h0,
      DPBRW_KIND_BLK_WR = 2'h1,
      DPBRW_KIND_SV_WR  = 2'h2,
      DPBRW_KIND_BAD    = 2'h3
   } dpbrw_kind_type;

   // descriptor and header layout
   localparam int          DPBRW_DESC_W      = 13;
   localparam int          DPBRW_DESC_FLAGS  = 8;
   localparam logic [7:0]  DPBRW_BTI_STATELESS = 8'hff;
   localparam int          DPBRW_X_ALIGN_W   = 3;
   localparam int          DPBRW_Y_ALIGN_W   = 2;
   localparam int          DPBRW_DIDX_TOP    = 27;
   localparam logic [2:0]  DPBRW_HDR_X       = 3'h0;
   localparam logic [2:0]  DPBRW_HDR_Y       = 3'h1;
   localparam logic [2:0]  DPBRW_HDR_MASK    = 3'h2;
   localparam logic [2:0]  DPBRW_HDR_DISP    = 3'h5;
   localparam logic [2:0]  DPBRW_SV_A        = 3'h3;
   localparam logic [2:0]  DPBRW_SV_IDX      = 3'h5;

   // beat counts
   localparam logic [5:0]  DPBRW_HDR_BEATS   = 6'h08;
   localparam logic [5:0]  DPBRW_BLK_WR_BEATS = 6'h28;
   localparam logic [4:0]  DPBRW_WB_LAST     = 5'h1f;

endpackage

// file: hdl/dpbrw_pack.sv
/*
 dpbrw_pack: maps a payload or writeback dword number to the pixel
 pair and channel pair it carries.
 assumes: dword number = register (4:3) and dword in register (2:0).
*/
`timescale 1ns/100ps
`default_nettype none

module dpbrw_pack (
   input  wire logic [4:0] dword_num,
   output logic      [4:0] pix_lo,
   output logic      [4:0] pix_hi,
   output logic            chan_hi
);
   import dpbrw_pkg::*;

   // dword order 1/0,3/2,9/8,11/10,5/4,7/6,13/12,15/14 per half
   always_comb begin
      pix_lo  = {dword_num[3], dword_num[1], dword_num[2],
                 dword_num[0], 1'b0};
      pix_hi  = {dword_num[3], dword_num[1], dword_num[2],
                 dword_num[0], 1'b1};
      chan_hi = dword_num[4];
   end

endmodule // dpbrw_pack

`default_nettype wire

// file: tb/dpbrw_dev.sv
/*
 dpbrw_dev: behavioural data port that takes message dwords with random
 stalls, logs them and answers a block read with 32 writeback dwords.
 assumes: one clock shared with the requester.
*/
`timescale 1ns/100ps
`default_nettype none
module dpbrw_dev (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        msg_valid,
   output logic             msg_ready,
   input  wire logic [31:0] msg_data,
   input  wire logic        msg_last,
   input  wire logic [1:0]  msg_kind,
   output logic             wb_valid,
   output logic [31:0]      wb_data,
   input  wire logic        wb_ready
);
   logic [31:0] pix [32];
   logic [31:0] log_q [40];
   int          tot, idx, wn, nw;
   logic        rd_pend;
   function automatic logic [31:0] wb_word(input logic [4:0] n);
      logic [4:0] lo;
      lo = {n[3], n[1], n[2], n[0], 1'b0}; // rowwise pairs
      return n[4] ? {pix[lo + 5'd1][31:16], pix[lo][31:16]}
                  : {pix[lo + 5'd1][15:0], pix[lo][15:0]};
   endfunction
   // one block inside the modelled surface, nothing clipped
   initial for (int i = 0; i < 32; i++) pix[i] = $urandom;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_ready <= 1'b0;
         wb_valid <= 1'b0;
         wb_data <= 32'h0;
         tot <= 0;
         idx <= 0;
         wn <= 0;
         rd_pend <= 1'b0;
      end else begin
         nw = wn + int'(wb_valid && wb_ready);
         wn <= nw;
         if (nw == 32) rd_pend <= 1'b0;
         msg_ready <= ($urandom_range(0, 3) != 0);
         if (msg_valid && msg_ready) begin
            log_q[idx] <= msg_data;
            idx <= msg_last ? 0 : idx + 1;
            tot <= tot + 1;
            // only a read asks for data back
            if (msg_last && msg_kind == 2'h0) begin
               rd_pend <= 1'b1;
               wn <= 0;
            end
         end
         // mask ignored, every pixel returned
         if (rd_pend && wb_ready && nw < 32 && $urandom_range(0, 2) != 0) begin
            wb_valid <= 1'b1;
            wb_data <= wb_word(5'(nw));
         end else begin
            wb_valid <= 1'b0;
            wb_data <= ~wb_data; // released line never keeps its value
         end
      end
   end
endmodule // dpbrw_dev
`default_nettype wire

// file: tb/dpbrw_host_tb_top.sv
/*
 dpbrw_host_tb_top: random and corner tests of the requester over apb.
 assumes: dpbrw_dev stands on the message and writeback links.
*/
`timescale 1ns/100ps
`default_nettype none
module dpbrw_host_tb_top;
   import dpbrw_pkg::*;
   logic                    pclk = 1'b0, presetn = 1'b0, er;
   logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]              paddr = 8'h00;
   logic [31:0]             pwdata = 32'h0, prdata, wb_data, msg_data, rd;
   logic                    pready, pslverr, msg_valid, msg_ready, msg_last;
   logic                    msg_eot, wb_valid, wb_ready;
   logic [1:0]              msg_kind;
   logic [DPBRW_DESC_W-1:0] msg_desc;
   logic [3:0]              msg_exec;
   logic [31:0]             pw [32];
   logic [31:0]             x, y, m, v, f;
   int                      error_cnt = 0, samples_checked = 0, t0;
   logic [31:0]             bad_ctrl [6] = '{32'h3, 32'h1, 32'hd, 32'h5,
                                             32'h5, 32'h7};
   always #5 pclk = ~pclk;
   dpbrw_host i_dpbrw_host (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .msg_valid, .msg_ready,
      .msg_data, .msg_last, .msg_kind, .msg_desc, .msg_eot, .msg_exec,
      .wb_valid, .wb_data, .wb_ready);
   dpbrw_dev i_dpbrw_dev (.pclk, .presetn, .msg_valid, .msg_ready,
      .msg_data, .msg_last, .msg_kind, .wb_valid, .wb_data, .wb_ready);
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(negedge pclk); while (pready !== 1'b1 && k++ < 20);
      cmp("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run(input logic [31:0] ctrl);
      int k;
      k = 0;
      t0 = i_dpbrw_dev.tot;
      apb(1'b1, DPBRW_CTRL_OFS, ctrl);
      do apb(1'b0, DPBRW_STATUS_OFS, 32'h0);
      while (rd[2:1] == 2'b00 && k++ < 100);
   endtask
   function automatic logic [31:0] pay(input logic [4:0] n);
      logic [4:0] lo;
      lo = {n[3], n[1], n[2], n[0], 1'b0};
      return n[4] ? {pw[lo + 5'd1][31:16], pw[lo][31:16]}
                  : {pw[lo + 5'd1][15:0], pw[lo][15:0]};
   endfunction
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hfc6f5e28));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, DPBRW_STATUS_OFS, 32'h0);
      cmp("status", 32'h0, rd);
      apb(1'b0, 8'h24, 32'h0);
      cmp("hole data", 32'h0, rd);
      cmp("hole err", 32'h1, {31'h0, er});
      apb(1'b1, 8'h81, 32'hffffffff);
      cmp("odd err", 32'h1, {31'h0, er});
      apb(1'b0, 8'h80, 32'h0);
      cmp("odd write", 32'h0, rd);
      $display("test reset done");
      for (int it = 0; it < 4; it++) begin
         x = (it == 0) ? 32'hfffffff8 : $urandom & ~32'h7;
         y = (it == 0) ? 32'hfffffffc : $urandom & ~32'h3;
         m = (it == 1) ? 32'h0 : $urandom;
         v = $urandom;
         apb(1'b1, DPBRW_XOFF_OFS, x);
         apb(1'b1, DPBRW_YOFF_OFS, y);
         apb(1'b1, DPBRW_MASK_OFS, m);
         apb(1'b1, DPBRW_DISP_OFS, v);
         for (int p = 0; p < 32; p++) begin
            pw[p] = $urandom;
            apb(1'b1, 8'h80 + 8'(p * 4), pw[p]);
         end
         f = $urandom;
         run({25'h0, f[2:0], f[3], 3'h3});
         cmp("wr status", 32'h2, rd & 32'h7);
         cmp("wr dwords", 32'd40, i_dpbrw_dev.tot - t0);
         cmp("x", x, i_dpbrw_dev.log_q[0]);
         cmp("y", y, i_dpbrw_dev.log_q[1]);
         cmp("mask", m, i_dpbrw_dev.log_q[2]);
         cmp("disp", {24'h0, v[7:0]}, i_dpbrw_dev.log_q[5]);
         for (int n = 0; n < 32; n++)
            cmp("payload", pay(5'(n)), i_dpbrw_dev.log_q[8 + n]);
         cmp("wr kind", 32'h1, {30'h0, msg_kind});
         cmp("blk desc", {21'h0, f[2:0], 8'h0}, {19'h0, msg_desc});
         cmp("blk eot", {31'h0, f[3]}, {31'h0, msg_eot});
         apb(1'b1, DPBRW_STATUS_OFS, 32'h6);
         run(32'h1);
         cmp("rd dwords", 32'd8, i_dpbrw_dev.tot - t0);
         cmp("rd kind", 32'h0, {30'h0, msg_kind});
         for (int p = 0; p < 32; p++) begin
            apb(1'b0, 8'h80 + 8'(p * 4), 32'h0);
            cmp("pixel", i_dpbrw_dev.pix[p], rd);
         end
         apb(1'b1, DPBRW_STATUS_OFS, 32'h6);
         $display("test block %0d done", it);
      end
      for (int it = 0; it < 4; it++) begin
         v = (it == 0) ? 32'h07ffffff : $urandom & 32'h07ffffff;
         m = $urandom_range(0, 254);
         f = $urandom;
         for (int p = 0; p < 4; p++) begin
            pw[p] = $urandom;
            apb(1'b1, 8'h80 + 8'(p * 4), pw[p]);
         end
         apb(1'b1, DPBRW_DIDX_OFS, v);
         apb(1'b1, DPBRW_BTI_OFS, m);
         apb(1'b1, DPBRW_EXEC_OFS, f);
         run({25'h0, f[2:0], 4'h5});
         cmp("sv dwords", 32'd8, i_dpbrw_dev.tot - t0);
         for (int p = 0; p < 4; p++)
            cmp("tuple", pw[p], i_dpbrw_dev.log_q[p]);
         cmp("index", v, i_dpbrw_dev.log_q[5]);
         cmp("desc", {21'h0, f[2:0], m[7:0]}, {19'h0, msg_desc});
         cmp("exec", {28'h0, f[3:0]}, {28'h0, msg_exec});
         cmp("eot", 32'h0, {31'h0, msg_eot});
         apb(1'b1, DPBRW_STATUS_OFS, 32'h6);
         $display("test stream %0d done", it);
      end
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, DPBRW_XOFF_OFS, (c == 0) ? 32'h4 : 32'h0);
         apb(1'b1, DPBRW_YOFF_OFS, (c == 1) ? 32'h2 : 32'h0);
         apb(1'b1, DPBRW_BTI_OFS, (c == 3) ? 32'hff : 32'h0);
         apb(1'b1, DPBRW_DIDX_OFS, (c == 4) ? 32'h08000000 : 32'h0);
         run(bad_ctrl[c]);
         cmp("bad status", 32'h4, rd & 32'h7);
         cmp("bad dwords", 32'd0, i_dpbrw_dev.tot - t0);
         apb(1'b1, DPBRW_STATUS_OFS, 32'h6);
      end
      $display("test refusals done");
      print_verdict();
   end
   initial begin
      #500000;
      error_cnt++;
      print_verdict();
   end
endmodule // dpbrw_host_tb_top
`default_nettype wire
